/* rtl/modem_pin_pkg.sv */
// constants for the modem pin function configuration block
// Functional notes
// (R1) pull-up only acts while pin is input
// (R2) pull-down needs input and pull-up clear
// (R3) ring field: input, open-drain, push-pull, else invalid
// (R4) terminal-ready codes 000/001/010 are general modes
// (R5) 011/100 terminal-ready modem output; 101-111 invalid
// (R6) software pairs modem output with set-ready input
// (R7) set-ready field: input, open-drain, push-pull, 11 invalid
// (R8) software writes zero to reserved middle bits
// (R9) data register bit 7 enables receive pull-up
// (R10) bit 6 receive pull-down unless pull-up set
// (R11) bit 5 receive wake needs global wake enable
// (R12) bit 0 selects transmit open-drain or push-pull
// (R13) set-ready pulls govern the set-ready pin
package modem_pin_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ring_cfg_addr = 8'h2b;
    localparam logic [7:0] term_cfg_addr = 8'h2c;
    localparam logic [7:0] set_cfg_addr = 8'h2d;
    localparam logic [7:0] data_cfg_addr = 8'h2e;
    localparam logic [7:0] cfg_reset = 8'h00;
    // ****************************************
    // field positions
    // ****************************************
    localparam int pull_up_bit = 7;
    localparam int pull_down_bit = 6;
    localparam int rx_wake_bit = 5;
    localparam int tx_drive_bit = 0;
    // ****************************************
    // function codes
    // ****************************************
    localparam logic [2:0] fn_input = 3'h0;
    localparam logic [2:0] fn_open_drain = 3'h1;
    localparam logic [2:0] fn_push_pull = 3'h2;
    localparam logic [2:0] fn_modem_od = 3'h3;
    localparam logic [2:0] fn_modem_pp = 3'h4;
endpackage : modem_pin_pkg

/* rtl/modem_pin_function_config.sv */
// register file and pin driver decode for the modem control and data pins
`timescale 1ns/100ps
`default_nettype none
module modem_pin_function_config
    import modem_pin_pkg::*;
(
    input wire logic clk_in, // core clock, 40 MHz
    input wire logic reset_n_in, // synchronous reset, active low
    input wire logic [7:0] reg_addr_in, // register offset
    input wire logic reg_write_in, // write strobe, one cycle
    input wire logic [7:0] reg_wdata_in, // write data
    output logic [7:0] reg_rdata_out, // read data, registered
    input wire logic [2:0] gen_out_in, // general output level: ring, term, set
    input wire logic term_modem_level_in, // terminal-ready level from the uart
    input wire logic global_wake_en_in, // global remote wake enable
    input wire logic [2:0] pin_in, // pin levels: ring, term, set
    output logic [2:0] pin_data_out, // synchronised pin levels
    output logic [2:0] pin_out, // pin drive levels
    output logic [2:0] pin_oe_out, // pin output enables, high drives
    output logic [2:0] pin_pull_up_out, // pull-up enables
    output logic [2:0] pin_pull_down_out, // pull-down enables
    output logic [2:0] pin_cfg_invalid_out, // function code not legal
    input wire logic rx_pin_in, // receive data pin
    output logic rx_pull_up_out, // receive pull-up enable
    output logic rx_pull_down_out, // receive pull-down enable
    output logic rx_wake_out, // receive activity wake request, one cycle
    input wire logic tx_data_in, // transmit data from the uart
    output logic tx_out, // transmit pin level
    output logic tx_oe_out // transmit pin output enable
);
    // ****************************************
    // registers
    // ****************************************
    logic [7:0] ring_pin_config;
    logic [7:0] terminal_ready_pin_config;
    logic [7:0] set_ready_pin_config;
    logic [7:0] serial_data_pin_config;
    logic [7:0] next_ring, next_term, next_set, next_data, next_rdata;
    logic [2:0] sync_a, sync_b;
    logic rx_a, rx_b, rx_c;

    // write decode; reserved bits are stored as written, software keeps them zero
    always_comb begin
        next_ring = ring_pin_config;
        next_term = terminal_ready_pin_config;
        next_set = set_ready_pin_config;
        next_data = serial_data_pin_config;
        if (reg_write_in) begin
            unique case (reg_addr_in)
                ring_cfg_addr: next_ring = reg_wdata_in;
                term_cfg_addr: next_term = reg_wdata_in;
                set_cfg_addr: next_set = reg_wdata_in;
                data_cfg_addr: next_data = reg_wdata_in;
                default: ;
            endcase
        end
        unique case (reg_addr_in)
            ring_cfg_addr: next_rdata = ring_pin_config;
            term_cfg_addr: next_rdata = terminal_ready_pin_config;
            set_cfg_addr: next_rdata = set_ready_pin_config;
            data_cfg_addr: next_rdata = serial_data_pin_config;
            default: next_rdata = 8'h00; // unmapped reads as zero
        endcase
    end

    // register stage
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            ring_pin_config <= cfg_reset;
            terminal_ready_pin_config <= cfg_reset;
            set_ready_pin_config <= cfg_reset;
            serial_data_pin_config <= cfg_reset;
            reg_rdata_out <= 8'h00;
            sync_a <= 3'h0;
            sync_b <= 3'h0;
            rx_a <= 1'b1;
            rx_b <= 1'b1;
            rx_c <= 1'b1;
        end else begin
            ring_pin_config <= next_ring;
            terminal_ready_pin_config <= next_term;
            set_ready_pin_config <= next_set;
            serial_data_pin_config <= next_data;
            reg_rdata_out <= next_rdata;
            sync_a <= pin_in;
            sync_b <= sync_a;
            rx_a <= rx_pin_in;
            rx_b <= rx_a;
            rx_c <= rx_b;
        end
    end

    assign pin_data_out = sync_b;

    // ****************************************
    // pin decode
    // ****************************************
    logic [2:0] fn [3];
    logic [7:0] cfg [3];
    assign cfg[0] = ring_pin_config;
    assign cfg[1] = terminal_ready_pin_config;
    assign cfg[2] = set_ready_pin_config; // pulls apply to this pin, see (R13)
    assign fn[0] = {1'b0, ring_pin_config[1:0]}; // see (R3)
    assign fn[1] = terminal_ready_pin_config[2:0]; // see (R4)
    assign fn[2] = {1'b0, set_ready_pin_config[1:0]}; // see (R7)

    // invalid codes leave the pin as an undriven input; its configured pulls still apply
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_pin
            logic is_input, od, pp, lvl;
            assign od = (fn[g] == fn_open_drain) || (g == 1 && fn[g] == fn_modem_od); // see (R5)
            assign pp = (fn[g] == fn_push_pull) || (g == 1 && fn[g] == fn_modem_pp); // see (R5)
            assign is_input = !(od || pp);
            assign pin_cfg_invalid_out[g] = is_input && fn[g] != fn_input; // see (R3)
            assign lvl = (g == 1 && fn[g] >= fn_modem_od) ? term_modem_level_in : gen_out_in[g];
            assign pin_out[g] = pp ? lvl : 1'b0;
            assign pin_oe_out[g] = pp || (od && !lvl);
            assign pin_pull_up_out[g] = is_input && cfg[g][pull_up_bit]; // see (R1)
            assign pin_pull_down_out[g] = is_input && !cfg[g][pull_up_bit]
                && cfg[g][pull_down_bit]; // see (R2)
        end
    endgenerate

    // ****************************************
    // data pins
    // ****************************************
    assign rx_pull_up_out = serial_data_pin_config[pull_up_bit]; // see (R9)
    assign rx_pull_down_out = !serial_data_pin_config[pull_up_bit]
        && serial_data_pin_config[pull_down_bit]; // see (R10)
    // any edge on the receive line counts as activity
    assign rx_wake_out = serial_data_pin_config[rx_wake_bit] && global_wake_en_in
        && (rx_b != rx_c); // see (R11)
    assign tx_out = serial_data_pin_config[tx_drive_bit] ? tx_data_in : 1'b0; // see (R12)
    assign tx_oe_out = serial_data_pin_config[tx_drive_bit] || !tx_data_in; // see (R12)

    // ****************************************
    // checks
    // ****************************************
    property p_pull_up_input;
        @(posedge clk_in) disable iff (!reset_n_in)
        pin_oe_out[0] |-> !pin_pull_up_out[0];
    endproperty
    a_pull_up_input: assert property (p_pull_up_input) else $error("pull-up active"); // see (R1)
    property p_pull_prio;
        @(posedge clk_in) disable iff (!reset_n_in)
        !(pin_pull_up_out[2] && pin_pull_down_out[2]);
    endproperty
    a_pull_prio: assert property (p_pull_prio) else $error("both pulls on"); // see (R2)
    property p_ring_pp;
        @(posedge clk_in) disable iff (!reset_n_in)
        ring_pin_config[1:0] == 2'h2 |-> pin_oe_out[0] && pin_out[0] == gen_out_in[0];
    endproperty
    a_ring_pp: assert property (p_ring_pp) else $error("ring push-pull wrong"); // see (R3)
    property p_term_od;
        @(posedge clk_in) disable iff (!reset_n_in)
        terminal_ready_pin_config[2:0] == 3'h1 |-> pin_oe_out[1] == !gen_out_in[1];
    endproperty
    a_term_od: assert property (p_term_od) else $error("term open-drain wrong"); // see (R4)
    property p_term_modem;
        @(posedge clk_in) disable iff (!reset_n_in)
        terminal_ready_pin_config[2:0] == 3'h4 |-> pin_out[1] == term_modem_level_in;
    endproperty
    a_term_modem: assert property (p_term_modem) else $error("modem level wrong"); // see (R5)
    property p_set_bad;
        @(posedge clk_in) disable iff (!reset_n_in)
        set_ready_pin_config[1:0] == 2'h3 |-> pin_cfg_invalid_out[2] && !pin_oe_out[2];
    endproperty
    a_set_bad: assert property (p_set_bad) else $error("invalid code not flagged"); // see (R7)
    property p_rx_pull;
        @(posedge clk_in) disable iff (!reset_n_in)
        reg_write_in && reg_addr_in == data_cfg_addr && reg_wdata_in[7:6] == 2'h3
        |=> rx_pull_up_out && !rx_pull_down_out;
    endproperty
    a_rx_pull: assert property (p_rx_pull) else $error("rx pull wrong"); // see (R10)
    property p_rx_wake;
        @(posedge clk_in) disable iff (!reset_n_in)
        rx_wake_out |-> global_wake_en_in && serial_data_pin_config[rx_wake_bit];
    endproperty
    a_rx_wake: assert property (p_rx_wake) else $error("wake without enable"); // see (R11)
    property p_tx_od;
        @(posedge clk_in) disable iff (!reset_n_in)
        !serial_data_pin_config[tx_drive_bit] && tx_data_in |-> !tx_oe_out;
    endproperty
    a_tx_od: assert property (p_tx_od) else $error("tx open-drain drives high"); // see (R12)
    property p_tx_pp;
        @(posedge clk_in) disable iff (!reset_n_in)
        serial_data_pin_config[tx_drive_bit] |-> tx_oe_out && tx_out == tx_data_in;
    endproperty
    a_tx_pp: assert property (p_tx_pp) else $error("tx push-pull wrong"); // see (R12)
    // further checks on all three pins, including invalid codes and pulls: open-drain only ever pulls low
    property p_ring_od;
        @(posedge clk_in) disable iff (!reset_n_in)
        ring_pin_config[1:0] == 2'h1 |-> !pin_out[0] && pin_oe_out[0] == !gen_out_in[0];
    endproperty
    a_ring_od: assert property (p_ring_od) else $error("ring open-drain wrong"); // see (R3)
    property p_term_pp;
        @(posedge clk_in) disable iff (!reset_n_in)
        terminal_ready_pin_config[2:0] == 3'h2 |-> pin_oe_out[1] && pin_out[1] == gen_out_in[1];
    endproperty
    a_term_pp: assert property (p_term_pp) else $error("term push-pull wrong"); // see (R4)
    property p_term_bad;
        @(posedge clk_in) disable iff (!reset_n_in)
        terminal_ready_pin_config[2:0] > 3'h4 |-> pin_cfg_invalid_out[1] && !pin_oe_out[1];
    endproperty
    a_term_bad: assert property (p_term_bad) else $error("term invalid not flagged"); // see (R5)
    property p_set_od;
        @(posedge clk_in) disable iff (!reset_n_in)
        set_ready_pin_config[1:0] == 2'h1 |-> !pin_out[2] && pin_oe_out[2] == !gen_out_in[2];
    endproperty
    a_set_od: assert property (p_set_od) else $error("set open-drain wrong"); // see (R7)
    property p_set_pull_off;
        @(posedge clk_in) disable iff (!reset_n_in)
        pin_oe_out[2] |-> !pin_pull_up_out[2] && !pin_pull_down_out[2];
    endproperty
    a_set_pull_off: assert property (p_set_pull_off) else $error("set pull while driving"); // see (R13)
    // written values land on the next edge and read back one cycle after the address
    property p_cfg_write;
        @(posedge clk_in) disable iff (!reset_n_in)
        reg_write_in && reg_addr_in == term_cfg_addr
        |=> terminal_ready_pin_config == $past(reg_wdata_in);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("write did not land"); // see (R4)
    property p_read_back;
        @(posedge clk_in) disable iff (!reset_n_in)
        reg_addr_in == set_cfg_addr |=> reg_rdata_out == $past(set_ready_pin_config);
    endproperty
    a_read_back: assert property (p_read_back) else $error("read data wrong"); // see (R7)
endmodule : modem_pin_function_config
`default_nettype wire

/* bench/modem_pin_peer.sv */
// pin-side peripheral model that resolves each modem pin level
`timescale 1ns/100ps
`default_nettype none
module modem_pin_peer (
    input wire logic clk_in, // core clock
    input wire logic [2:0] drive_in, // device drive levels
    input wire logic [2:0] oe_in, // device output enables
    input wire logic [2:0] pull_up_in, // device pull-up enables
    input wire logic [2:0] pull_down_in, // device pull-down enables
    output logic [2:0] level_out // resolved pin levels
);
    logic [2:0] wander = 3'h5;
    // an open pin wanders every cycle so a stale level never looks valid
    always_ff @(posedge clk_in) begin
        wander <= ~wander;
    end
    // the peripheral stays quiet; device drive wins, then pulls, then noise
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (oe_in[i]) level_out[i] = drive_in[i];
            else if (pull_up_in[i]) level_out[i] = 1'b1;
            else if (pull_down_in[i]) level_out[i] = 1'b0;
            else level_out[i] = wander[i];
        end
    end
endmodule : modem_pin_peer
`default_nettype wire

/* bench/modem_pin_function_config_tb.sv */
// self-checking bench for the modem pin function configuration block
`timescale 1ns/100ps
`default_nettype none
module modem_pin_function_config_tb;
    import modem_pin_pkg::*;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic reg_write_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic [2:0] gen_out_in = 3'h7;
    logic term_modem_level_in = 1'b0;
    logic global_wake_en_in = 1'b0;
    logic rx_pin_in = 1'b1;
    logic tx_data_in = 1'b1;
    logic [7:0] reg_rdata_out;
    logic [2:0] pin_in, pin_data_out, pin_out, pin_oe_out, pin_pull_up_out, pin_pull_down_out;
    logic [2:0] pin_cfg_invalid_out;
    logic rx_pull_up_out, rx_pull_down_out, rx_wake_out, tx_out, tx_oe_out;
    int fail_count = 0;
    int checks_done = 0;
    int pulses = 0;
    int base;
    int idx;
    logic [20:0] rows [14];
    always #12.5 clk_in = ~clk_in;
    modem_pin_function_config dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .reg_addr_in(reg_addr_in), .reg_write_in(reg_write_in), .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out), .gen_out_in(gen_out_in), .pin_in(pin_in),
        .term_modem_level_in(term_modem_level_in), .global_wake_en_in(global_wake_en_in),
        .pin_data_out(pin_data_out), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
        .pin_pull_up_out(pin_pull_up_out), .pin_pull_down_out(pin_pull_down_out),
        .pin_cfg_invalid_out(pin_cfg_invalid_out), .rx_pin_in(rx_pin_in),
        .rx_pull_up_out(rx_pull_up_out), .rx_pull_down_out(rx_pull_down_out),
        .rx_wake_out(rx_wake_out), .tx_data_in(tx_data_in), .tx_out(tx_out),
        .tx_oe_out(tx_oe_out));
    modem_pin_peer peer (.clk_in(clk_in), .drive_in(pin_out), .oe_in(pin_oe_out),
        .pull_up_in(pin_pull_up_out), .pull_down_in(pin_pull_down_out), .level_out(pin_in));
    // wake pulses are counted so a stretched pulse shows up as extra counts
    always @(posedge clk_in) begin
        if (rx_wake_out === 1'b1) pulses <= pulses + 1;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            fail_count++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : check
    // inputs move 2 ns after the edge so no sampling race is possible
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #2;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_write_in = 1'b1;
        tick(1);
        reg_write_in = 1'b0;
    endtask : wr
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        // addr, data, expected {oe, out, pull-up, pull-down, invalid}; reserved bits kept 0
        rows = '{{8'h2b, 8'h80, 5'h04}, {8'h2b, 8'hc0, 5'h04}, {8'h2b, 8'h40, 5'h02},
            {8'h2b, 8'h81, 5'h00}, {8'h2b, 8'hc2, 5'h18}, {8'h2b, 8'h43, 5'h03},
            {8'h2c, 8'hc1, 5'h00}, {8'h2c, 8'h02, 5'h18}, {8'h2c, 8'h83, 5'h10},
            {8'h2c, 8'h04, 5'h10}, {8'h2c, 8'h45, 5'h03}, {8'h2d, 8'h42, 5'h18},
            {8'h2d, 8'h40, 5'h02}, {8'h2d, 8'h03, 5'h01}};
        tick(6);
        reset_n_in = 1'b1;
        wr(8'h2a, 8'hff);
        for (int a = 8'h2a; a <= 8'h2e; a++) begin
            reg_addr_in = 8'(a);
            tick(1);
            check(reg_rdata_out, cfg_reset);
        end
        check(8'(pin_oe_out), 8'h00);
        $display("test reset and unmapped done");
        foreach (rows[i]) begin
            idx = int'(rows[i][20:13] - 8'h2b);
            wr(rows[i][20:13], rows[i][12:5]);
            check(8'({pin_oe_out[idx], pin_out[idx], pin_pull_up_out[idx],
                pin_pull_down_out[idx], pin_cfg_invalid_out[idx]}),
                8'(rows[i][4:0]));
            tick(1);
            check(reg_rdata_out, rows[i][12:5]);
            tick(1);
            // resolved level: driven value, else pull-up high, else pull-down low
            if (rows[i][4:1] != 4'h0) begin
                check(8'(pin_data_out[idx]),
                    8'(rows[i][4] ? rows[i][3] : rows[i][2]));
            end
        end
        $display("test pin rows done");
        // drive levels at both settings of the general and modem level inputs
        gen_out_in = 3'h0;
        term_modem_level_in = 1'b1;
        wr(8'h2b, 8'h02);
        tick(1);
        wr(8'h2c, 8'h01);
        tick(1);
        wr(8'h2d, 8'h01);
        check(8'({pin_oe_out, pin_out}), 8'h38);
        gen_out_in = 3'h7;
        tick(1);
        check(8'({pin_oe_out, pin_out}), 8'h09);
        wr(8'h2d, 8'h00); // set-ready back to input before any modem code
        tick(1);
        wr(8'h2c, 8'h03);
        check(8'({pin_oe_out, pin_out}), 8'h09);
        term_modem_level_in = 1'b0;
        tick(1);
        check(8'({pin_oe_out, pin_out}), 8'h19);
        term_modem_level_in = 1'b1;
        wr(8'h2c, 8'h04);
        check(8'({pin_oe_out, pin_out}), 8'h1b);
        $display("test pin levels done");
        tick(1);
        wr(8'h2e, 8'hc1);
        check({6'h00, rx_pull_up_out, rx_pull_down_out}, 8'h02);
        check({6'h00, tx_oe_out, tx_out}, 8'h03);
        tick(1);
        wr(8'h2e, 8'h40);
        check({6'h00, rx_pull_up_out, rx_pull_down_out}, 8'h01);
        check({6'h00, tx_oe_out, tx_out}, 8'h00);
        tx_data_in = 1'b0;
        tick(1);
        check({6'h00, tx_oe_out, tx_out}, 8'h02);
        for (int g = 0; g < 3; g++) begin
            wr(8'h2e, (g == 2) ? 8'h00 : 8'h20);
            global_wake_en_in = (g != 0);
            base = pulses;
            rx_pin_in = ~rx_pin_in;
            tick(6);
            check(8'(pulses - base), (g == 1) ? 8'h01 : 8'h00);
        end
        $display("test data pins done");
        wr(8'h2e, 8'h81);
        reset_n_in = 1'b0;
        tick(1);
        reset_n_in = 1'b1;
        tick(1);
        check(reg_rdata_out, cfg_reset);
        check(8'(pin_oe_out), 8'h00);
        check({6'h00, rx_pull_up_out, rx_pull_down_out}, 8'h00);
        $display("test mid-run reset done");
        results();
    end
    initial begin
        #50000;
        fail_count++;
        results();
    end
endmodule : modem_pin_function_config_tb
`default_nettype wire
